// ===== rtl/bbx_excl_monitor.sv
`timescale 1ns/10ps
`include "bbx_regs.svh"
module bbx_excl_monitor (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic load_ex_i,
  input  wire logic store_ex_i,
  input  wire logic clear_excl_tag_i,
  input  wire logic exception_i,
  output logic      tag_o
);
  typedef struct packed {
    logic tag;
  } bbx_mon_s;
  bbx_mon_s r;
  bbx_mon_s next_r;

  always_comb begin
    next_r = r;
    if (load_ex_i) begin
      next_r.tag = 1'b1;               // [R5]
    end
    // clearing events win over a same-cycle load
    if (clear_excl_tag_i || store_ex_i || exception_i) begin
      next_r.tag = 1'b0;               // [R11] [R12] [R13]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign tag_o = r.tag;

  AST_TAG_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R5]
    load_ex_i && !store_ex_i && !clear_excl_tag_i && !exception_i |=> tag_o)
    else $error("tag not set by exclusive load");
  AST_TAG_CLR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [R11]
    clear_excl_tag_i || exception_i |=> !tag_o)
    else $error("tag not cleared");
endmodule

// ===== rtl/bbx_mem_access.sv
`timescale 1ns/10ps
`include "bbx_regs.svh"
// Notes on behaviour
// R1: alias write changes only its mapped bit, set from bit 0 of data.
// R2: bits 31:1 of alias write data are ignored.
// R3: alias read returns 0x0 or 0x1 from the mapped bit.
// R4: memory byte-addressed from zero, little-endian words.
// R5: exclusive load returns data and sets the exclusive tag.
// R6: exclusive store status 0 means written, 1 means not written.
// R7: exclusive pairs exist for word, halfword and byte sizes.
// R8: core pairs each exclusive load with the matching-size store.
// R9: core retries load-modify-store sequence after a failed status.
// R10: core claims a semaphore only on successful exclusive store status.
// R11: clear-exclusive operation clears the tag.
// R12: every exclusive store clears the tag, pass or fail.
// R13: a taken exception clears the tag.
// R14: alias writes are read-modify-write of the underlying byte.
// R15: alias address = base + byte offset*32 + bit number*4.
// R16: exclusive store succeeds only if tag set when it executes.
module bbx_mem_access
  import bbx_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             req_i,
  input  wire bbx_pkg::bbx_op_e op_i,
  input  wire bbx_pkg::bbx_size_e size_i,
  input  wire logic [31:0]      addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             exception_i,
  output logic                  busy_o,
  output logic                  rvalid_o,
  output logic [31:0]           rdata_o,
  output logic                  status_o
);
  import bbx_pkg::*;

  typedef struct packed {
    logic [1:0]                             rst_sync;
    bbx_state_e                             state;
    logic [`BBX_MEM_AW-1:0]                 rmw_word;
    logic [1:0]                             rmw_lane;
    logic [2:0]                             rmw_bit;
    logic                                   rmw_val;
    logic                                   busy;
    logic                                   rvalid;
    logic [31:0]                            rdata;
    logic                                   status;
    logic [`BBX_MEM_WORDS-1:0][31:0]        mem;
  } bbx_top_s;

  bbx_top_s r;
  bbx_top_s next_r;
  logic     rst_n;
  logic     tag;
  logic     is_load_ex;
  logic     is_store_ex;
  logic     is_clear_ex;

  // helpers for the checks at the bottom
  logic [31:0]            rmw_cur;
  logic [31:0]            rmw_mask;
  logic [`BBX_MEM_AW-1:0] req_idx;
  logic [31:0]            req_word;

  assign rmw_cur  = r.mem[r.rmw_word];
  assign rmw_mask = 32'h0000_0001 << {r.rmw_lane, r.rmw_bit};
  assign req_idx  = word_idx(addr_i);
  assign req_word = r.mem[req_idx];

  // alias address decode [R15]
  function automatic logic in_alias(input logic [31:0] a);
    return (a >= `BBX_ALIAS_BASE) && (a <= `BBX_ALIAS_TOP);
  endfunction

  function automatic logic [31:0] alias_byte(input logic [31:0] a);
    logic [31:0] off;
    off = a - `BBX_ALIAS_BASE;
    return `BBX_BAND_BASE + (off >> `BBX_WORD_SHIFT);
  endfunction

  function automatic logic [2:0] alias_bit(input logic [31:0] a);
    return a[`BBX_BITNUM_LSB +: 3];
  endfunction

  // only low memory words are backed; band window aliases onto it
  function automatic logic [`BBX_MEM_AW-1:0] word_idx(input logic [31:0] a);
    return a[2 +: `BBX_MEM_AW];
  endfunction

  // little-endian lane extract [R4]
  function automatic logic [31:0] rd_sized(input logic [31:0] w, input logic [1:0] lane,
                                            input bbx_size_e sz);
    logic [31:0] s;
    s = w >> {lane, 3'b000};
    case (sz)
      BBX_SZ_BYTE: rd_sized = {24'h00_0000, s[7:0]};
      BBX_SZ_HALF: rd_sized = {16'h0000, s[15:0]};
      default:     rd_sized = w;
    endcase
  endfunction

  // little-endian lane merge [R4]
  function automatic logic [31:0] wr_sized(input logic [31:0] w, input logic [1:0] lane,
                                            input bbx_size_e sz, input logic [31:0] d);
    logic [31:0] m;
    logic [31:0] v;
    case (sz)
      BBX_SZ_BYTE: m = 32'h0000_00FF;
      BBX_SZ_HALF: m = 32'h0000_FFFF;
      default:     m = 32'hFFFF_FFFF;
    endcase
    m = m << {lane, 3'b000};
    v = d << {lane, 3'b000};
    wr_sized = (w & ~m) | (v & m);
  endfunction

  assign rst_n       = r.rst_sync[1];
  assign is_load_ex  = req_i && !r.busy && (op_i == BBX_OP_LOAD_EX);
  assign is_store_ex = req_i && !r.busy && (op_i == BBX_OP_STORE_EX);
  assign is_clear_ex = req_i && !r.busy && (op_i == BBX_OP_CLEAR_EX);

  bbx_excl_monitor u_mon (
    .ref_clk_i        (ref_clk_i),
    .rst_n_i          (rst_n),
    .load_ex_i        (is_load_ex),
    .store_ex_i       (is_store_ex),
    .clear_excl_tag_i (is_clear_ex),
    .exception_i      (exception_i),
    .tag_o            (tag)
  );

  always_comb begin
    logic [31:0]            ba;
    logic [`BBX_MEM_AW-1:0] wi;
    logic [31:0]            cur;
    ba  = '0;
    wi  = '0;
    cur = '0;
    next_r          = r;
    next_r.rst_sync = {r.rst_sync[0], 1'b1};
    next_r.rvalid   = 1'b0;
    case (r.state)
      BBX_ST_IDLE: begin
        // requests wait for the synchronised reset release
        if (req_i && rst_n && op_i != BBX_OP_NONE) begin
          wi  = word_idx(addr_i);
          cur = r.mem[wi];
          if (in_alias(addr_i) && (op_i == BBX_OP_READ || op_i == BBX_OP_WRITE)) begin
            ba = alias_byte(addr_i);
            wi = word_idx(ba);
            cur = r.mem[wi];
            if (op_i == BBX_OP_READ) begin
              next_r.rvalid = 1'b1;
              next_r.rdata  = cur[{ba[1:0], alias_bit(addr_i)}] ?
                              `BBX_ALIAS_ONE : `BBX_ALIAS_ZERO; // [R3]
            end else begin
              // read-modify-write takes a second cycle [R14]
              next_r.state    = BBX_ST_RMW;
              next_r.busy     = 1'b1;
              next_r.rmw_word = wi;
              next_r.rmw_lane = ba[1:0];
              next_r.rmw_bit  = alias_bit(addr_i);
              next_r.rmw_val  = wdata_i[0]; // [R1] [R2]
            end
          end else begin
            case (op_i)
              BBX_OP_READ, BBX_OP_LOAD_EX: begin // [R5] [R7]
                next_r.rvalid = 1'b1;
                next_r.rdata  = rd_sized(cur, addr_i[1:0], size_i);
              end
              BBX_OP_WRITE: begin
                next_r.mem[wi] = wr_sized(cur, addr_i[1:0], size_i, wdata_i);
              end
              BBX_OP_STORE_EX: begin
                next_r.rvalid = 1'b1;
                next_r.rdata  = '0;
                if (tag && !exception_i) begin // [R16]
                  next_r.mem[wi] = wr_sized(cur, addr_i[1:0], size_i, wdata_i); // [R7]
                  next_r.status  = `BBX_STAT_OK; // [R6]
                end else begin
                  next_r.status  = `BBX_STAT_FAIL; // [R6]
                end
              end
              BBX_OP_CLEAR_EX: begin
                next_r.rvalid = 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
      end
      BBX_ST_RMW: begin
        cur = r.mem[r.rmw_word];
        cur[{r.rmw_lane, r.rmw_bit}] = r.rmw_val; // [R14]
        next_r.mem[r.rmw_word] = cur;
        next_r.state  = BBX_ST_IDLE;
        next_r.busy   = 1'b0;
        next_r.rvalid = 1'b1;
      end
      default: begin
        next_r.state = BBX_ST_IDLE;
        next_r.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy_o   = r.busy;
  assign rvalid_o = r.rvalid;
  assign rdata_o  = r.rdata;
  assign status_o = r.status;

  sequence s_alias_wr;
    req_i && !busy_o && op_i == BBX_OP_WRITE && in_alias(addr_i);
  endsequence
  sequence s_rmw_done;
    busy_o ##1 (!busy_o && rvalid_o);
  endsequence

  AST_RMW_TWO_CYCLE: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R14]
    s_alias_wr |=> s_rmw_done)
    else $error("alias write did not finish in two cycles");
  AST_ALIAS_READ_01: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R3]
    req_i && !busy_o && op_i == BBX_OP_READ && in_alias(addr_i)
    |=> rvalid_o && rdata_o[31:1] == 31'h0)
    else $error("alias read not 0 or 1");
  AST_STEX_FAIL: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R16]
    req_i && !busy_o && op_i == BBX_OP_STORE_EX && !tag |=> rvalid_o && status_o)
    else $error("store-exclusive without tag succeeded");
  AST_STEX_OK: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R6]
    req_i && !busy_o && op_i == BBX_OP_STORE_EX && tag && !exception_i
    |=> rvalid_o && !status_o)
    else $error("store-exclusive with tag failed");
  AST_STEX_CLEARS: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R12]
    is_store_ex |=> !tag)
    else $error("tag survived store-exclusive");
  AST_EXC_CLEARS: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R13]
    exception_i |=> !tag)
    else $error("tag survived exception");
  AST_LDEX_TAG: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R5]
    is_load_ex && !exception_i |=> tag && rvalid_o)
    else $error("exclusive load did not tag");
  AST_ALIAS_WR_BIT: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R1]
    s_alias_wr ##1 busy_o |=> r.mem[$past(r.rmw_word)][{$past(r.rmw_lane),
      $past(r.rmw_bit)}] == $past(r.rmw_val))
    else $error("alias write bit wrong");

  sequence s_stex_taken;
    is_store_ex;
  endsequence
  sequence s_stex_answer;
    rvalid_o && rdata_o == 32'h0000_0000;
  endsequence

  // neighbours of the target bit must come back untouched
  AST_RMW_KEEP: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R14]
    s_alias_wr ##1 busy_o |=> ((rmw_cur ^ $past(rmw_cur)) & ~rmw_mask) == 32'h0000_0000)
    else $error("alias write disturbed other bits");

  AST_BUSY_SINGLE: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R14]
    busy_o |=> !busy_o)
    else $error("busy held longer than one cycle");

  // a lost store must leave every word as it was
  AST_STEX_NO_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R6]
    is_store_ex && (!tag || exception_i) |=> $stable(r.mem))
    else $error("failed store-exclusive wrote memory");

  AST_STATUS_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R6]
    !is_store_ex |=> $stable(status_o))
    else $error("status changed without store-exclusive");

  AST_CLEAR_ACK: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R11]
    is_clear_ex |=> rvalid_o && !tag)
    else $error("clear-exclusive not answered");

  AST_ALIAS_RD_STILL: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R3]
    req_i && !busy_o && op_i == BBX_OP_READ && in_alias(addr_i)
    |=> $stable(r.mem))
    else $error("alias read changed memory");

  AST_LDEX_DATA: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R5]
    is_load_ex && size_i == BBX_SZ_WORD |=> rdata_o == $past(req_word))
    else $error("exclusive word load returned wrong data");

  AST_STEX_ACK: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R6]
    s_stex_taken |=> s_stex_answer)
    else $error("store-exclusive not answered");

  // aligned word store only, sub-word lanes are left to the bench
  AST_STEX_WRITES: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R6]
    is_store_ex && tag && !exception_i && size_i == BBX_SZ_WORD && addr_i[1:0] == 2'b00
    |=> r.mem[$past(req_idx)] == $past(wdata_i))
    else $error("successful store-exclusive did not write");

  // the tag can only come up from an exclusive load
  AST_TAG_FROM_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_n) // [R5]
    $rose(tag) |-> $past(is_load_ex))
    else $error("tag set without exclusive load");
endmodule

// ===== rtl/bbx_pkg.sv
package bbx_pkg;
  typedef enum logic [1:0] {
    BBX_SZ_BYTE = 2'b00,
    BBX_SZ_HALF = 2'b01,
    BBX_SZ_WORD = 2'b10
  } bbx_size_e;
  typedef enum logic [2:0] {
    BBX_OP_NONE     = 3'b000,
    BBX_OP_READ     = 3'b001,
    BBX_OP_WRITE    = 3'b010,
    BBX_OP_LOAD_EX  = 3'b011,
    BBX_OP_STORE_EX = 3'b100,
    BBX_OP_CLEAR_EX = 3'b101
  } bbx_op_e;
  typedef enum logic [1:0] {
    BBX_ST_IDLE = 2'b00,
    BBX_ST_RMW  = 2'b01
  } bbx_state_e;
endpackage

// ===== rtl/bbx_regs.svh
`ifndef BBX_REGS_SVH
`define BBX_REGS_SVH
`define BBX_ALIAS_BASE   32'h2200_0000
`define BBX_ALIAS_TOP    32'h23FF_FFFF
`define BBX_BAND_BASE    32'h2000_0000
`define BBX_WORD_SHIFT   5
`define BBX_BITNUM_LSB   2
`define BBX_MEM_WORDS    64
`define BBX_MEM_AW       6
`define BBX_ALIAS_ZERO   32'h0000_0000
`define BBX_ALIAS_ONE    32'h0000_0001
`define BBX_STAT_OK      1'b0
`define BBX_STAT_FAIL    1'b1
`endif

// ===== testbench/bbx_core_model.sv
`timescale 1ns/10ps
module bbx_core_model
  import bbx_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          rvalid_i,
  input  wire logic [31:0]   rdata_i,
  input  wire logic          status_i,
  output logic               req_o,
  output bbx_pkg::bbx_op_e   op_o,
  output bbx_pkg::bbx_size_e size_o,
  output logic [31:0]        addr_o,
  output logic [31:0]        wdata_o
);
  initial begin
    req_o = 1'b0;
    op_o = BBX_OP_NONE;
    size_o = BBX_SZ_WORD;
    addr_o = 32'h0;
    wdata_o = 32'h0;
  end
  // one request at a time, held up to the taking edge
  task automatic xfer(input bbx_op_e op, input bbx_size_e sz, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rd, output logic st);
    @(posedge ref_clk_i);
    req_o <= 1'b1;
    op_o <= op;
    size_o <= sz;
    addr_o <= a;
    wdata_o <= d;
    @(posedge ref_clk_i);
    req_o <= 1'b0;
    op_o <= BBX_OP_NONE;
    addr_o <= ~a;
    // released data lines show the inverse, not a stale copy
    wdata_o <= ~d;
    // answer is taken at the edge that sees rvalid high
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      if (rvalid_i === 1'b1) break;
    end
    rd = rdata_i;
    st = status_i;
  endtask
  // semaphore claim, gives up after three lost races
  task automatic claim(input logic [31:0] a, output logic ok);
    logic [31:0] rd;
    logic        st;
    ok = 1'b0;
    for (int t = 0; t < 3; t++) begin
      xfer(BBX_OP_LOAD_EX, BBX_SZ_WORD, a, 32'h0, rd, st);
      if (rd !== 32'h0) break;
      xfer(BBX_OP_STORE_EX, BBX_SZ_WORD, a, 32'h1, rd, st);
      ok = (st === 1'b0);
      if (ok) break;
    end
  endtask
endmodule

// ===== testbench/bbx_mem_access_tb.sv
`timescale 1ns/10ps
`include "bbx_regs.svh"
module bbx_mem_access_tb;
  import bbx_pkg::*;
  logic        ref_clk_i;
  logic        reset_n_i;
  logic        exception_i;
  logic        req;
  logic        busy;
  logic        rvalid;
  logic        status;
  bbx_op_e     op;
  bbx_size_e   size;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd;
  logic [31:0] w;
  logic [31:0] d;
  logic [31:0] a;
  logic [31:0] m;
  logic [7:0]  off;
  logic [2:0]  b;
  logic        st;
  logic        ok;
  int          n_errors = 0;
  int          checks = 0;
  int          seed = 4;
  int          n_busy = 0;
  logic [31:0] r2_tab [4] = '{32'h01, 32'hFF, 32'h00, 32'h0E};
  bbx_size_e   sz_tab [3] = '{BBX_SZ_BYTE, BBX_SZ_HALF, BBX_SZ_WORD};
  logic [31:0] mk_tab [3] = '{32'hFF, 32'hFFFF, 32'hFFFF_FFFF};

  bbx_mem_access DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_i(req), .op_i(op),
    .size_i(size), .addr_i(addr), .wdata_i(wdata), .exception_i(exception_i),
    .busy_o(busy), .rvalid_o(rvalid), .rdata_o(rdata), .status_o(status));
  bbx_core_model core (.ref_clk_i(ref_clk_i), .rvalid_i(rvalid), .rdata_i(rdata),
    .status_i(status), .req_o(req), .op_o(op), .size_o(size), .addr_o(addr), .wdata_o(wdata));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // alias writes are the only source of busy cycles
  always @(posedge ref_clk_i) begin
    if (busy === 1'b1) n_busy++;
  end

  function automatic logic [31:0] alias_of(input logic [7:0] o, input logic [2:0] n);
    return `BBX_ALIAS_BASE + {24'h0, o} * 32 + {29'h0, n} * 4;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(6000 * 25);
    n_errors++;
    report_and_stop;
  end

  initial begin
    exception_i = 1'b0;
    reset_n_i = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    for (int k = 0; k < 4; k++)
      core.xfer(BBX_OP_WRITE, BBX_SZ_BYTE, 32'h2000_0010 + k, 32'h11 * (k + 1), rd, st);
    core.xfer(BBX_OP_READ, BBX_SZ_WORD, 32'h2000_0010, 32'h0, rd, st);
    chk("le_word", 32'h4433_2211, rd);
    // first four data values are the fixed upper-bit cases
    for (int i = 0; i < 12; i++) begin
      off = 8'($random(seed));
      b = 3'($random(seed));
      w = $random(seed);
      d = (i < 4) ? r2_tab[i] : $random(seed);
      a = `BBX_BAND_BASE + {24'h0, off[7:2], 2'b00};
      core.xfer(BBX_OP_WRITE, BBX_SZ_WORD, a, w, rd, st);
      core.xfer(BBX_OP_WRITE, BBX_SZ_WORD, alias_of(off, b), d, rd, st);
      w[{off[1:0], b}] = d[0];
      core.xfer(BBX_OP_READ, BBX_SZ_WORD, a, 32'h0, rd, st);
      chk("band_word", w, rd);
      core.xfer(BBX_OP_READ, BBX_SZ_WORD, alias_of(off, b), 32'h0, rd, st);
      chk("alias_read", {31'h0, d[0]}, rd);
    end
    chk("busy_cycles", 32'h0000_000C, n_busy);
    for (int j = 0; j < 3; j++) begin
      a = 32'h2000_0040 + 4 * j;
      m = mk_tab[j];
      w = $random(seed);
      d = $random(seed);
      core.xfer(BBX_OP_WRITE, BBX_SZ_WORD, a, w, rd, st);
      core.xfer(BBX_OP_LOAD_EX, sz_tab[j], a, 32'h0, rd, st);
      chk("ldx_data", w & m, rd & m);
      core.xfer(BBX_OP_STORE_EX, sz_tab[j], a, d, rd, st);
      chk("stx_first", {31'h0, `BBX_STAT_OK}, {31'h0, st});
      core.xfer(BBX_OP_STORE_EX, sz_tab[j], a, ~d, rd, st);
      chk("stx_again", {31'h0, `BBX_STAT_FAIL}, {31'h0, st});
      core.xfer(BBX_OP_READ, BBX_SZ_WORD, a, 32'h0, rd, st);
      chk("stx_mem", (w & ~m) | (d & m), rd);
    end
    for (int j = 0; j < 2; j++) begin
      core.xfer(BBX_OP_LOAD_EX, BBX_SZ_WORD, a, 32'h0, rd, st);
      if (j == 0) core.xfer(BBX_OP_CLEAR_EX, BBX_SZ_WORD, a, 32'h0, rd, st);
      else begin
        @(posedge ref_clk_i);
        exception_i <= 1'b1;
        @(posedge ref_clk_i);
        exception_i <= 1'b0;
      end
      core.xfer(BBX_OP_STORE_EX, BBX_SZ_WORD, a, 32'h5, rd, st);
      chk("stx_cleared", {31'h0, `BBX_STAT_FAIL}, {31'h0, st});
    end
    core.xfer(BBX_OP_WRITE, BBX_SZ_WORD, 32'h2000_0050, 32'h0, rd, st);
    core.claim(32'h2000_0050, ok);
    chk("claim_free", 32'h1, {31'h0, ok});
    core.claim(32'h2000_0050, ok);
    chk("claim_taken", 32'h0, {31'h0, ok});
    report_and_stop;
  end
endmodule
